// file: deil_pkg.sv
// package for the dual external interrupt latch: offsets, bit positions, resets
package deil_pkg;
   localparam int         ADDR_W          = 8;              // register address width
   localparam int         DATA_W          = 8;              // register data width
   localparam int         NUM_CH          = 2;              // channel count
   localparam logic [7:0] SECOND_SC_OFF   = 8'h1C;          // second channel status/control
   localparam logic [7:0] FIRST_SC_OFF    = 8'h1E;          // first channel status/control
   localparam int         SENS_BIT        = 0;              // sensitivity select
   localparam int         BLOCK_BIT       = 1;              // request block (mask)
   localparam int         CLEAR_BIT       = 2;              // clear strobe (write only)
   localparam int         PEND_BIT        = 3;              // pending flag (read only)
   localparam int         PULLUP_DIS_BIT  = 6;              // pullup disable, second channel only
   localparam logic [7:0] SC_RESET        = 8'h00;          // reset value of both registers
   localparam logic [1:0] SYNC_RESET      = 2'h3;           // pins idle high under pullups
endpackage

// file: deil_ch_if.sv
// interface carrying one channel's controls and state between top and channel latch
`timescale 1ns/100ps
interface deil_ch_if;
   logic pinSync;     // synchronised pin level
   logic pinPrev;     // previous synchronised sample
   logic levelMode;   // 1: edge plus low level
   logic clearReq;    // one-cycle acknowledge (vector fetch or software)
   logic pending;     // latch state
   modport top (output pinSync, output pinPrev, output levelMode, output clearReq, input pending);
   modport ch  (input pinSync, input pinPrev, input levelMode, input clearReq, output pending);
endinterface

// file: deil_latch.sv
// one channel's request latch with edge or edge-plus-level sensitivity
`timescale 1ns/100ps
module deil_latch
   import deil_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   deil_ch_if.ch    chIf
);
   logic pend_ff;       // request latch
   logic ackSeen_ff;    // level mode: acknowledge already given
   logic fallEdge;      // registered-sample falling edge

   assign fallEdge = chIf.pinPrev & ~chIf.pinSync;
   assign chIf.pending = pend_ff;

   // latch: set wins over clear so no edge is lost
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pend_ff <= 1'b0;
      end else if (fallEdge) begin
         pend_ff <= 1'b1;
      end else if (chIf.levelMode) begin
         // level mode needs acknowledge and pin high, either order
         if ((chIf.clearReq | ackSeen_ff) & chIf.pinSync) begin
            pend_ff <= 1'b0;
         end else if (!chIf.pinSync) begin
            pend_ff <= 1'b1;
         end
      end else if (chIf.clearReq) begin
         pend_ff <= 1'b0;
      end
   end

   // remembers an acknowledge given while the pin is still low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ackSeen_ff <= 1'b0;
      end else if (!chIf.levelMode || fallEdge || chIf.pinSync) begin
         ackSeen_ff <= 1'b0;
      end else if (chIf.clearReq && pend_ff) begin
         ackSeen_ff <= 1'b1;
      end
   end

   pend_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      fallEdge |=> pend_ff) else $error("falling edge did not latch");
   edge_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!chIf.levelMode && chIf.clearReq && !fallEdge) |=> !pend_ff) else $error("edge clear failed");
   lvl_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (chIf.levelMode && !chIf.pinSync) |=> pend_ff) else $error("low level not held");
   lvl_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (chIf.levelMode && chIf.clearReq && chIf.pinSync && !fallEdge) |=> !pend_ff)
      else $error("level clear failed");
   edge_cv: cover property (@(posedge clk) disable iff (sys_rst) fallEdge ##1 chIf.clearReq);
   lvl_cv: cover property (@(posedge clk) disable iff (sys_rst)
      chIf.levelMode && ackSeen_ff ##[1:20] !pend_ff);
endmodule

// file: deil_top.sv
// dual external interrupt latch: pins, register port, cpu request outputs
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
module deil_top
   import deil_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              ext_int_pin_a,       // active-low pin, first channel
   input  wire logic              ext_int_pin_b,       // active-low pin, second channel
   input  wire logic [ADDR_W-1:0] regAddr,             // register address
   input  wire logic [DATA_W-1:0] regWrData,           // register write data
   input  wire logic              regWrEn,             // write strobe
   input  wire logic              regRdEn,             // read strobe
   output logic      [DATA_W-1:0] regRdData_ff,        // read data, cycle after strobe
   input  wire logic              vecFetchA,           // cpu fetching first vector
   input  wire logic              vecFetchB,           // cpu fetching second vector
   input  wire logic              cpuIntMask,          // cpu global interrupt mask
   input  wire logic              breakState,          // debug break active
   input  wire logic              break_clear_enable,  // break flag control bit
   output logic      [NUM_CH-1:0] cpuIrq_ff,           // requests to priority logic
   output logic                   branchPinLevel_ff,   // level for branch-on-pin
   output logic                   pullupEnA_ff,        // first pin pullup on
   output logic                   pullupEnB_ff         // second pin pullup on
);
   // address decode, shared by write and read paths
   function automatic logic [NUM_CH-1:0] decode(input logic [ADDR_W-1:0] a);
      decode = {a == SECOND_SC_OFF, a == FIRST_SC_OFF};
   endfunction

   logic [1:0]        syncA_ff;        // pin a synchroniser, [0] first stage
   logic [1:0]        syncB_ff;        // pin b synchroniser
   logic [NUM_CH-1:0] prev_ff;         // previous synchronised samples
   logic [NUM_CH-1:0] sens_ff;         // sensitivity select per channel
   logic [NUM_CH-1:0] block_ff;        // request block per channel
   logic              pullupDisB_ff;   // second pin pullup disable
   logic [NUM_CH-1:0] sel;             // decoded register select
   logic [NUM_CH-1:0] swClear;         // software clear this cycle
   logic [NUM_CH-1:0] pend;            // latch states
   logic [NUM_CH-1:0] pinS;            // synchronised pins
   logic [NUM_CH-1:0] vecFetch;        // vector fetch acknowledges
   logic              clearAllowed;    // break gate for software clears
   logic [DATA_W-1:0] nxt_rdData;      // read mux

   assign sel      = decode(regAddr);
   assign pinS     = {syncB_ff[1], syncA_ff[1]};
   assign vecFetch = {vecFetchB, vecFetchA};
   // in break, clears land only when enabled; a landed clear stays cleared
   assign clearAllowed = !breakState || break_clear_enable;
   assign swClear  = (regWrEn && regWrData[CLEAR_BIT] && clearAllowed) ? sel : '0;

   // two-flop synchronisers; only the second stage is looked at
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         syncA_ff <= SYNC_RESET;
         syncB_ff <= SYNC_RESET;
      end else begin
         syncA_ff <= {syncA_ff[0], ext_int_pin_a};
         syncB_ff <= {syncB_ff[0], ext_int_pin_b};
      end
   end

   // registered previous sample for edge compare
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_ff <= '1;
      end else begin
         prev_ff <= pinS;
      end
   end

   // per-channel latches
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gCh
         deil_ch_if chIf ();
         assign chIf.pinSync   = pinS[g];
         assign chIf.pinPrev   = prev_ff[g];
         assign chIf.levelMode = sens_ff[g];
         // each vector fetch acknowledges only its own channel
         assign chIf.clearReq  = vecFetch[g] | swClear[g];
         assign pend[g]        = chIf.pending;
         deil_latch uLatch (
            .clk     (clk),
            .sys_rst (sys_rst),
            .chIf    (chIf)
         );
      end
   endgenerate

   // sensitivity and block bits, written per register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sens_ff  <= '0;
         block_ff <= '0;
      end else if (regWrEn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (sel[i]) begin
               sens_ff[i]  <= regWrData[SENS_BIT];
               block_ff[i] <= regWrData[BLOCK_BIT];
            end
         end
      end
   end

   // second pin pullup disable, only in the second register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pullupDisB_ff <= 1'b0;
      end else if (regWrEn && sel[1]) begin
         pullupDisB_ff <= regWrData[PULLUP_DIS_BIT];
      end
   end

   // read mux; clear bits and unused bits read zero
   always_comb begin
      nxt_rdData = SC_RESET;
      for (int i = 0; i < NUM_CH; i++) begin
         if (sel[i]) begin
            nxt_rdData[SENS_BIT]  = sens_ff[i];
            nxt_rdData[BLOCK_BIT] = block_ff[i];
            nxt_rdData[PEND_BIT]  = pend[i];
         end
      end
      if (sel[1]) begin
         nxt_rdData[PULLUP_DIS_BIT] = pullupDisB_ff;
      end
      // clear bit never driven, reads zero
      nxt_rdData[CLEAR_BIT] = 1'b0;
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regRdData_ff <= SC_RESET;
      end else if (regRdEn) begin
         regRdData_ff <= nxt_rdData;
      end else begin
         regRdData_ff <= '0;
      end
   end

   // requests to priority logic gated by block bits and global mask
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cpuIrq_ff <= '0;
      end else begin
         // one cycle late vs latch; software should block level channels in handler
         cpuIrq_ff <= pend & ~block_ff & {NUM_CH{!cpuIntMask}};
      end
   end

   // branch level and pullups
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         branchPinLevel_ff <= 1'b1;
         pullupEnA_ff      <= 1'b1;
         pullupEnB_ff      <= 1'b1;
      end else begin
         branchPinLevel_ff <= syncA_ff[1];
         pullupEnA_ff      <= 1'b1;
         pullupEnB_ff      <= !pullupDisB_ff;
      end
   end

   irq_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      (block_ff[0] || cpuIntMask) |=> !cpuIrq_ff[0]) else $error("masked request reached cpu");
   glob_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      cpuIntMask |=> cpuIrq_ff == '0) else $error("global mask ignored");
   break_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (breakState && !break_clear_enable) |-> swClear == '0) else $error("clear in break");
   read_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regRdEn && sel[0]) |=> regRdData_ff[PEND_BIT] == $past(pend[0])) else $error("flag read wrong");
   clear_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      regRdData_ff[CLEAR_BIT] == 1'b0) else $error("clear bit read one");
   pullup_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      $past(pullupDisB_ff) |-> !pullupEnB_ff) else $error("pullup b not off");
   vec_only_a: assert property (@(posedge clk) disable iff (sys_rst)
      (vecFetchA && !vecFetchB && !swClear[1] && sens_ff[1] == 1'b0 && pend[1]) |=> pend[1])
      else $error("fetch cleared other channel");
   branch_a: assert property (@(posedge clk) disable iff (sys_rst)
      branchPinLevel_ff == $past(syncA_ff[1])) else $error("branch level wrong");

   // a first-register write lands in the first sensitivity bit
   sens_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regWrEn && sel[0]) |=> sens_ff[0] == $past(regWrData[SENS_BIT]))
      else $error("first sensitivity write lost");

   // second channel sensitivity, same bit position
   sens_wr_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regWrEn && sel[1]) |=> sens_ff[1] == $past(regWrData[SENS_BIT]))
      else $error("second sensitivity write lost");

   // block bits follow the written data
   block_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regWrEn && sel[0]) |=> block_ff[0] == $past(regWrData[BLOCK_BIT]))
      else $error("first block write lost");

   // second block bit
   block_wr_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regWrEn && sel[1]) |=> block_ff[1] == $past(regWrData[BLOCK_BIT]))
      else $error("second block write lost");

   // pullup disable only moves on a second-register write
   pud_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regWrEn && sel[1]) |=> pullupDisB_ff == $past(regWrData[PULLUP_DIS_BIT]))
      else $error("pullup disable write lost");

   // a first-register write must leave the pullup bit alone
   pud_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regWrEn && sel[0]) |=> $stable(pullupDisB_ff))
      else $error("pullup bit moved by first register");

   // without a write strobe no control bit may move
   ctl_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !regWrEn |=> ($stable(sens_ff) && $stable(block_ff)))
      else $error("control bit moved without write");

   // unmapped addresses read back as zero
   unmap_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regRdEn && sel == 2'b00) |=> regRdData_ff == 8'h00)
      else $error("unmapped read not zero");

   // bits seven, five and four are never implemented
   unused_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regRdData_ff[7] == 1'b0) && (regRdData_ff[5:4] == 2'b00))
      else $error("unused bit read one");

   // first register has no pullup bit
   rd_no_pud_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regRdEn && sel[0]) |=> !regRdData_ff[PULLUP_DIS_BIT])
      else $error("pullup bit in first register");

   // second pending flag polled through its register
   read_flag_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regRdEn && sel[1]) |=> regRdData_ff[PEND_BIT] == $past(pend[1]))
      else $error("second flag read wrong");

   // read-back of the first sensitivity and block bits
   read_ctl_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regRdEn && sel[0]) |=> (regRdData_ff[SENS_BIT] == $past(sens_ff[0])
      && regRdData_ff[BLOCK_BIT] == $past(block_ff[0]))) else $error("first control read wrong");

   // second register read-back, pullup bit included
   read_ctl_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regRdEn && sel[1]) |=> (regRdData_ff[PULLUP_DIS_BIT] == $past(pullupDisB_ff)
      && regRdData_ff[SENS_BIT] == $past(sens_ff[1]))) else $error("second control read wrong");

   // second request hidden by its block bit or the global mask
   irq_mask_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (block_ff[1] || cpuIntMask) |=> !cpuIrq_ff[1])
      else $error("masked second request reached cpu");

   // an unblocked latch must reach the cpu one cycle later while the global mask is clear
   irq_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
      (pend[0] && !block_ff[0] && !cpuIntMask) |=> cpuIrq_ff[0])
      else $error("first request not passed");

   // same for the second channel
   irq_pass_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (pend[1] && !block_ff[1] && !cpuIntMask) |=> cpuIrq_ff[1])
      else $error("second request not passed");

   // a request never appears without its latch behind it
   irq_src_a: assert property (@(posedge clk) disable iff (sys_rst)
      cpuIrq_ff[0] |-> $past(pend[0]))
      else $error("request without latch");

   // blocking hides the request but keeps the latch
   latch_kept_a: assert property (@(posedge clk) disable iff (sys_rst)
      (block_ff[0] && pend[0] && !vecFetch[0] && !swClear[0] && !sens_ff[0]) |=> pend[0])
      else $error("blocked latch lost");

   // software clear in edge mode empties the latch at once
   sw_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (swClear[0] && !sens_ff[0] && !(prev_ff[0] && !pinS[0])) |=> !pend[0])
      else $error("software clear failed");

   // an allowed clear write must reach the latch
   clr_go_a: assert property (@(posedge clk) disable iff (sys_rst)
      (regWrEn && sel[0] && regWrData[CLEAR_BIT] && (!breakState || break_clear_enable)) |-> swClear[0])
      else $error("allowed clear dropped");

   // second channel fetch must not touch the first latch
   vec_only_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (vecFetchB && !vecFetchA && !swClear[0] && !sens_ff[0] && pend[0]) |=> pend[0])
      else $error("fetch cleared first channel");

   // own fetch clears an edge-mode latch
   vec_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (vecFetchA && !sens_ff[0] && !(prev_ff[0] && !pinS[0])) |=> !pend[0])
      else $error("fetch did not clear");

   // level mode keeps the second latch set while its pin is low
   lvl_low_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (sens_ff[1] && !pinS[1]) |=> pend[1])
      else $error("second low level not held");

   // a latch only rises after a low sample on its pin
   rise_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(pend[0]) |-> !$past(pinS[0]))
      else $error("latch set with pin high");

   // edge mode without an edge never sets the latch
   no_spur_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!sens_ff[0] && !pend[0] && !(prev_ff[0] && !pinS[0])) |=> !pend[0])
      else $error("latch set without edge");

   // second pin edge detect feeds its latch
   edge_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (prev_ff[1] && !pinS[1]) |=> pend[1])
      else $error("second edge not latched");

   // first pullup can never be switched off
   pull_a_on_a: assert property (@(posedge clk) disable iff (sys_rst)
      pullupEnA_ff == 1'b1)
      else $error("first pullup off");

   // second pullup follows the cleared disable bit
   pull_b_on_a: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(pullupDisB_ff) |-> pullupEnB_ff)
      else $error("second pullup not on");

   // reset empties latches, control bits and requests
   rst_clr_a: assert property (@(posedge clk)
      sys_rst |=> (pend == 2'b00 && sens_ff == 2'b00 && cpuIrq_ff == 2'b00))
      else $error("reset left state behind");

   // reset restores pullups, idle branch level and quiet read data
   rst_out_a: assert property (@(posedge clk)
      sys_rst |=> (pullupEnA_ff && pullupEnB_ff && branchPinLevel_ff && regRdData_ff == 8'h00))
      else $error("reset outputs wrong");
   irq_cv: cover property (@(posedge clk) disable iff (sys_rst) cpuIrq_ff[0] ##1 vecFetchA);
   brk_cv: cover property (@(posedge clk) disable iff (sys_rst) breakState && break_clear_enable && swClear[1]);
   rd_cv: cover property (@(posedge clk) disable iff (sys_rst) regRdEn && sel[1]);
endmodule

// file: deil_src_model.sv
// model of the external sources: open-drain, active-low drivers on both pins
`timescale 1ns/100ps
module deil_src_model (
   input  wire logic clk,        // bench clock
   input  wire logic lowA,       // source pulls first pin low
   input  wire logic lowB,       // source pulls second pin low
   input  wire logic pullupEnB,  // second pin pullup present
   output logic      pinA,       // first pin level
   output logic      pinB        // second pin level
);
   logic floatB = 1'b1;  // released second pin with no pullup
   // an unpulled released line wanders every cycle, so nobody may rely on it
   always @(posedge clk) begin
      floatB <= ~pinB;
   end
   // first pin always pulled up, second only when its pullup is on
   assign pinA = lowA ? 1'b0 : 1'b1;
   assign pinB = lowB ? 1'b0 : (pullupEnB ? 1'b1 : floatB);
endmodule

// file: deil_top_tb.sv
// self-checking testbench for the dual external interrupt latch
`timescale 1ns/100ps
module deil_top_tb
   import deil_pkg::*;
;
   logic              clk        = 1'b0;   // 250 MHz
   logic              sys_rst    = 1'b1;   // held for six cycles
   logic [ADDR_W-1:0] regAddr    = 8'h00;
   logic [DATA_W-1:0] regWrData  = 8'h00;
   logic              regWrEn    = 1'b0;
   logic              regRdEn    = 1'b0;
   logic              vecFetchA  = 1'b0;
   logic              vecFetchB  = 1'b0;
   logic              cpuIntMask = 1'b0;
   logic              breakState = 1'b0;
   logic              breakClrEn = 1'b0;
   logic              lowA       = 1'b0;   // source command, first pin
   logic              lowB       = 1'b0;   // source command, second pin
   logic [7:0]        rnd        = 8'h08;  // lfsr state, fixed seed
   int                badCount   = 0;
   int                numChecks  = 0;
   logic [DATA_W-1:0] regRdData_ff;
   logic [NUM_CH-1:0] cpuIrq_ff;
   logic              branchLvl, puA, puB, pinA, pinB;
   always #2 clk = ~clk;
   deil_src_model src (.clk(clk), .lowA(lowA), .lowB(lowB), .pullupEnB(puB), .pinA(pinA), .pinB(pinB));
   deil_top uut (.clk(clk), .sys_rst(sys_rst), .ext_int_pin_a(pinA), .ext_int_pin_b(pinB), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff),
      .vecFetchA(vecFetchA), .vecFetchB(vecFetchB), .cpuIntMask(cpuIntMask), .breakState(breakState),
      .break_clear_enable(breakClrEn), .cpuIrq_ff(cpuIrq_ff), .branchPinLevel_ff(branchLvl),
      .pullupEnA_ff(puA), .pullupEnB_ff(puB));
   // next random byte
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // expected register image: pullup disable only on second, clear reads zero
   function automatic logic [7:0] scExp(input logic isB, input logic [7:0] d, input logic pend);
      return {1'b0, isB & d[6], 2'b00, pend, 1'b0, d[1], d[0]};
   endfunction
   // requests, branch level and pullups packed in one byte
   function automatic logic [7:0] outs();
      return {3'b000, cpuIrq_ff, branchLvl, puA, puB};
   endfunction
   task automatic wrapUp();
      $display("comparisons %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // settle just after an edge so flop updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // write starts with a gap edge so strobes never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1;
      chk("read data", exp, regRdData_ff);
   endtask
   task automatic fetch(input logic [1:0] m);
      @(posedge clk);
      {vecFetchB, vecFetchA} <= m;
      @(posedge clk);
      {vecFetchB, vecFetchA} <= 2'b00;
   endtask
   // bounded wait for a request to reach the cpu
   task automatic waitIrq(input int i);
      for (int k = 0; k < 20; k++) begin
         tick(1);
         if (cpuIrq_ff[i] === 1'b1) return;
      end
      chk("request wait", 8'h01, 8'h00);
      wrapUp();
   endtask
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk("outputs", 8'h07, outs());
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         wr(rnd[7] ? FIRST_SC_OFF : SECOND_SC_OFF, rnd & 8'hBF);
         rd(rnd[7] ? FIRST_SC_OFF : SECOND_SC_OFF, scExp(!rnd[7], rnd & 8'hBF, 1'b0));
      end
      wr(FIRST_SC_OFF, 8'h00);
      wr(SECOND_SC_OFF, 8'h00);
      wr(8'h1D, 8'hFF);
      rd(8'h1D, 8'h00);
      rd(SECOND_SC_OFF, 8'h00);
      // both channels edge mode, both pins fall together
      @(posedge clk);
      lowA <= 1'b1;
      lowB <= 1'b1;
      waitIrq(0);
      waitIrq(1);
      rd(FIRST_SC_OFF, 8'h08);
      fetch(2'b01);
      tick(2);
      chk("requests", 8'h02, {6'h00, cpuIrq_ff});
      chk("branch level", 8'h00, {7'h00, branchLvl});
      @(posedge clk);
      lowA <= 1'b0;
      tick(4);
      chk("branch level", 8'h01, {7'h00, branchLvl});
      fetch(2'b10);
      tick(2);
      rd(SECOND_SC_OFF, 8'h00);
      // clear write, then a fresh falling edge must latch again
      wr(FIRST_SC_OFF, 8'h04);
      @(posedge clk);
      lowA <= 1'b1;
      waitIrq(0);
      wr(FIRST_SC_OFF, 8'h02);
      tick(2);
      chk("requests", 8'h00, {6'h00, cpuIrq_ff});
      rd(FIRST_SC_OFF, 8'h0A);
      wr(FIRST_SC_OFF, 8'h00);
      @(posedge clk);
      cpuIntMask <= 1'b1;
      tick(3);
      chk("requests", 8'h00, {6'h00, cpuIrq_ff});
      @(posedge clk);
      cpuIntMask <= 1'b0;
      tick(3);
      chk("requests", 8'h01, {6'h00, cpuIrq_ff});
      // break state: clears ignored by default, honoured when enabled
      @(posedge clk);
      breakState <= 1'b1;
      wr(FIRST_SC_OFF, 8'h04);
      rd(FIRST_SC_OFF, 8'h08);
      @(posedge clk);
      breakClrEn <= 1'b1;
      wr(FIRST_SC_OFF, 8'h04);
      @(posedge clk);
      breakState <= 1'b0;
      breakClrEn <= 1'b0;
      rd(FIRST_SC_OFF, 8'h00);
      // level mode on second channel, acknowledge before and after pin rise
      @(posedge clk);
      lowA <= 1'b0;
      lowB <= 1'b0;
      wr(SECOND_SC_OFF, 8'h01);
      @(posedge clk);
      lowB <= 1'b1;
      waitIrq(1);
      wr(SECOND_SC_OFF, 8'h07);
      rd(SECOND_SC_OFF, 8'h0B);
      chk("requests", 8'h00, {6'h00, cpuIrq_ff});
      @(posedge clk);
      lowB <= 1'b0;
      tick(6);
      rd(SECOND_SC_OFF, 8'h03);
      wr(SECOND_SC_OFF, 8'h01);
      @(posedge clk);
      lowB <= 1'b1;
      waitIrq(1);
      @(posedge clk);
      lowB <= 1'b0;
      tick(6);
      rd(SECOND_SC_OFF, 8'h09);
      fetch(2'b10);
      tick(2);
      rd(SECOND_SC_OFF, 8'h01);
      // pullup off while pin held low, then reset with the pin still low
      @(posedge clk);
      lowB <= 1'b1;
      waitIrq(1);
      wr(SECOND_SC_OFF, 8'h41);
      tick(2);
      chk("outputs", 8'h16, outs());
      rd(SECOND_SC_OFF, 8'h49);
      @(posedge clk);
      sys_rst <= 1'b1;
      tick(2);
      chk("outputs", 8'h07, outs());
      @(posedge clk);
      lowB <= 1'b0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd(SECOND_SC_OFF, 8'h00);
      wrapUp();
   end
endmodule
